// ---- rtl/cssq_sequencer.sv ----
// Purpose: Startup sequencing, code tracking and output-good logic of a core supply.
// Assumes: Pins are asynchronous; sensed and droop levels come from clk_sys logic.
// Notes: All state freezes while clk_en is low.
`timescale 1ns/1ps
module cssq_sequencer
  import cssq_pkg::*;
#(
  parameter int unsigned PG_DELAY_CYC = PG_DELAY_DEF,
  parameter logic [CODE_W-1:0] BOOT_CODE = BOOT_CODE_DEF
)
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic enable,
  input wire logic supply_lockout,
  input wire logic deep_sleep_request,
  input wire logic [CODE_W-1:0] voltage_select_inputs,
  input wire logic phase2_pullup,
  input wire logic phase3_pullup,
  input wire logic [LVL_W-1:0] sense_level,
  input wire logic [LVL_W-1:0] droop_level,
  output logic output_good_flag,
  output logic clock_release_n,
  output logic output_sense_ref_short,
  output logic bias_enable,
  output logic soft_start_go,
  output logic [1:0] phase_count,
  output logic [CODE_W-1:0] target_code,
  output logic [LVL_W-1:0] reference_level
);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] pin_meta;
  logic [SYNC_W-1:0] pin_sync;

  assign pin_raw = {enable, supply_lockout, deep_sleep_request, phase2_pullup,
                    phase3_pullup, voltage_select_inputs};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
        end else if (clk_en) begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  logic en_s;
  logic lock_s;
  logic ds_s;
  logic p2_s;
  logic p3_s;
  logic [CODE_W-1:0] sel_s;
  logic power_ok;

  assign en_s = pin_sync[11];
  assign lock_s = pin_sync[10];
  assign ds_s = pin_sync[9];
  assign p2_s = pin_sync[8];
  assign p3_s = pin_sync[7];
  assign sel_s = pin_sync[6:0];
  assign power_ok = en_s && !lock_s;

  // ==========================================================
  // Sequencer state machine
  // ==========================================================
  cssq_state_t state;
  cssq_state_t next_state;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_value;
  logic tmr_done;
  logic [1:0] det_cnt;
  logic p2_high;
  logic p3_high;
  logic at_goal;
  logic released;

  assign released = (state == ST_PGDLY) || (state == ST_RUN);

  always_comb begin
    next_state = state;
    tmr_load = 1'b0;
    tmr_value = '0;
    unique case (state)
      ST_SHUTDOWN: begin
        if (power_ok) begin
          next_state = ST_RESET;
          tmr_load = 1'b1;
          tmr_value = TMR_W'(RST_CYC);
        end
      end
      ST_RESET: begin
        if (tmr_done) begin
          next_state = ST_PHASE;
        end
      end
      ST_PHASE: begin
        if (det_cnt == 2'(PHASE_DET_CYC - 1)) begin
          next_state = ST_SOFT;
        end
      end
      ST_SOFT: begin
        if (at_goal) begin
          next_state = ST_BOOT;
          tmr_load = 1'b1;
          tmr_value = TMR_W'(BOOT_CYC);
        end
      end
      ST_BOOT: begin
        if (tmr_done) begin
          next_state = ST_PGDLY;
          tmr_load = 1'b1;
          tmr_value = TMR_W'(PG_DELAY_CYC);
        end
      end
      ST_PGDLY: begin
        if (tmr_done) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_SHUTDOWN;
      end
    endcase
    if (!power_ok) begin
      next_state = ST_SHUTDOWN;
      tmr_load = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= ST_SHUTDOWN;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  cssq_timer u_seq_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .clear(!power_ok),
    .load(tmr_load),
    .load_value(tmr_value),
    .busy(),
    .done(tmr_done)
  );

  // ==========================================================
  // Phase count detection
  // ==========================================================
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      det_cnt <= '0;
      p2_high <= 1'b0;
      p3_high <= 1'b0;
      phase_count <= PH_THREE;
    end else if (clk_en) begin
      if (state != ST_PHASE) begin
        det_cnt <= '0;
        p2_high <= 1'b1;
        p3_high <= 1'b1;
      end else begin
        det_cnt <= det_cnt + 1'b1;
        p2_high <= p2_high && p2_s;
        p3_high <= p3_high && p3_s;
        if (next_state == ST_SOFT) begin
          if (p2_high && p2_s && p3_high && p3_s) begin
            phase_count <= PH_ONE;
          end else if (p3_high && p3_s) begin
            phase_count <= PH_TWO;
          end else begin
            phase_count <= PH_THREE;
          end
        end
      end
    end
  end

  // ==========================================================
  // Sequence outputs
  // ==========================================================
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      clock_release_n <= 1'b1;
      soft_start_go <= 1'b0;
      bias_enable <= 1'b0;
      output_sense_ref_short <= 1'b1;
    end else if (clk_en) begin
      clock_release_n <= !(next_state == ST_PGDLY || next_state == ST_RUN);
      soft_start_go <= (next_state == ST_SOFT) || (next_state == ST_BOOT) ||
                       (next_state == ST_PGDLY) || (next_state == ST_RUN);
      bias_enable <= (next_state != ST_SHUTDOWN);
      output_sense_ref_short <= (next_state == ST_SHUTDOWN);
    end
  end

  // ==========================================================
  // Select code deglitch and acceptance
  // ==========================================================
  logic [CODE_W-1:0] sel_prev;
  logic [CODE_W-1:0] sel_taken;
  logic [DEGL_W-1:0] degl_cnt;
  logic sel_change;
  logic ds_prev;
  logic ds_edge;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sel_prev <= '0;
      degl_cnt <= '0;
      sel_taken <= BOOT_CODE;
      sel_change <= 1'b0;
    end else if (clk_en) begin
      sel_prev <= sel_s;
      sel_change <= 1'b0;
      if (!released) begin
        degl_cnt <= '0;
        sel_taken <= BOOT_CODE;
      end else if (sel_s != sel_prev) begin
        degl_cnt <= '0;
      end else if (degl_cnt != DEGL_W'(DEGL_CYC)) begin
        degl_cnt <= degl_cnt + 1'b1;
        if (degl_cnt == DEGL_W'(DEGL_CYC - 1) && sel_s != sel_taken) begin
          sel_taken <= sel_s;
          sel_change <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ds_prev <= 1'b0;
    end else if (clk_en) begin
      ds_prev <= ds_s;
    end
  end

  assign ds_edge = released && (ds_s != ds_prev);

  // ==========================================================
  // Target, reference and output-good window
  // ==========================================================
  logic [CODE_W-1:0] slew_goal;
  logic [LVL_W-1:0] dac_level;
  logic [LVL_W:0] sense_wide;
  logic [LVL_W:0] dac_wide;
  logic hi_ok;
  logic lo_ok;
  logic in_window;
  logic mask_busy;

  assign slew_goal = released ? sel_taken : BOOT_CODE;

  cssq_slew u_slew (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .hold(state == ST_SHUTDOWN || state == ST_RESET || state == ST_PHASE),
    .goal(slew_goal),
    .cur_code(target_code),
    .at_goal(at_goal)
  );

  cssq_timer u_mask_timer (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .clear(!power_ok),
    .load(sel_change || ds_edge),
    .load_value(TMR_W'(MASK_CYC)),
    .busy(mask_busy),
    .done()
  );

  assign dac_level = code_to_level(target_code);
  assign sense_wide = {1'b0, sense_level};
  assign dac_wide = {1'b0, dac_level};
  assign hi_ok = sense_wide <= dac_wide + WIN_HI_LVL;
  assign lo_ok = (dac_level < LOW_DAC_LVL) || (sense_wide + WIN_LO_LVL >= dac_wide);
  assign in_window = hi_ok && lo_ok;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reference_level <= '0;
    end else if (clk_en) begin
      reference_level <= (dac_level > droop_level) ? dac_level - droop_level : '0;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      output_good_flag <= 1'b0;
    end else if (clk_en) begin
      if (!power_ok || state == ST_SHUTDOWN) begin
        output_good_flag <= 1'b0;
      end else if (state == ST_PGDLY && tmr_done) begin
        output_good_flag <= 1'b1;
      end else if (state == ST_RUN && !mask_busy) begin
        output_good_flag <= in_window;
      end
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  property p_shutdown;
    @(posedge clk_sys) disable iff (!resetn)
    (clk_en && !power_ok) |=> state == ST_SHUTDOWN && clock_release_n && !output_good_flag;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("no shutdown on enable loss");

  property p_short;
    @(posedge clk_sys) disable iff (!resetn)
    (clk_en && !power_ok) |=> output_sense_ref_short && !bias_enable;
  endproperty
  a_short: assert property (p_short) else $error("sense reference not shorted");

  property p_release;
    @(posedge clk_sys) disable iff (!resetn)
    $fell(clock_release_n) |-> $past(state) == ST_BOOT && $past(tmr_done);
  endproperty
  a_release: assert property (p_release) else $error("clock release without boot hold");

  property p_good_rise;
    @(posedge clk_sys) disable iff (!resetn)
    ($rose(output_good_flag) && $past(state) == ST_PGDLY) |-> !clock_release_n && $past(tmr_done);
  endproperty
  a_good_rise: assert property (p_good_rise) else $error("good flag rose early");

  property p_window;
    @(posedge clk_sys) disable iff (!resetn)
    (clk_en && state == ST_RUN && !mask_busy && !in_window) |=> !output_good_flag;
  endproperty
  a_window: assert property (p_window) else $error("good flag high outside window");

  property p_low_dac;
    @(posedge clk_sys) disable iff (!resetn)
    (clk_en && power_ok && state == ST_RUN && !mask_busy && hi_ok &&
     dac_level < LOW_DAC_LVL) |=> output_good_flag;
  endproperty
  a_low_dac: assert property (p_low_dac) else $error("lower limit checked at low target");

  property p_mask_start;
    @(posedge clk_sys) disable iff (!resetn)
    (clk_en && power_ok && (sel_change || ds_edge)) |=> mask_busy;
  endproperty
  a_mask_start: assert property (p_mask_start) else $error("mask not started");

  property p_mask_hold;
    @(posedge clk_sys) disable iff (!resetn)
    (clk_en && power_ok && state == ST_RUN && mask_busy) |=> $stable(output_good_flag);
  endproperty
  a_mask_hold: assert property (p_mask_hold) else $error("good flag moved while masked");

  property p_ignore_sel;
    @(posedge clk_sys) disable iff (!resetn)
    clock_release_n |=> !sel_change;
  endproperty
  a_ignore_sel: assert property (p_ignore_sel) else $error("code taken before release");

  property p_degl;
    @(posedge clk_sys) disable iff (!resetn)
    sel_change |-> $past(degl_cnt) == DEGL_W'(DEGL_CYC - 1) && $past(sel_s) == $past(sel_prev);
  endproperty
  a_degl: assert property (p_degl) else $error("code accepted before settle time");

  property p_go;
    @(posedge clk_sys) disable iff (!resetn)
    $rose(soft_start_go) |-> $past(state) == ST_PHASE && $past(det_cnt) == 2'(PHASE_DET_CYC - 1);
  endproperty
  a_go: assert property (p_go) else $error("go issued before phase detect");

endmodule

// ---- rtl/cssq_slew.sv ----
// Purpose: Moves the regulation target code one LSB per step toward a goal.
// Assumes: goal is stable logic on clk_sys.
// Notes: hold parks the target at the zero-volt code.
`timescale 1ns/1ps
module cssq_slew
  import cssq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic hold,
  input wire logic [CODE_W-1:0] goal,
  output logic [CODE_W-1:0] cur_code,
  output logic at_goal
);

  localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYC - 1);

  logic [STEP_W-1:0] step_cnt;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      step_cnt <= '0;
      cur_code <= ZERO_CODE;
    end else if (clk_en) begin
      if (hold) begin
        step_cnt <= '0;
        cur_code <= ZERO_CODE;
      end else if (cur_code == goal) begin
        step_cnt <= '0;
      end else if (step_cnt == STEP_LAST) begin
        step_cnt <= '0;
        if (goal > cur_code) begin
          cur_code <= cur_code + 1'b1;
        end else begin
          cur_code <= cur_code - 1'b1;
        end
      end else begin
        step_cnt <= step_cnt + 1'b1;
      end
    end
  end

  assign at_goal = (cur_code == goal);

  property p_one_lsb;
    @(posedge clk_sys) disable iff (!resetn)
    (!$past(hold) && cur_code != $past(cur_code)) |->
      ($past(step_cnt) == STEP_LAST) &&
      (cur_code == $past(cur_code) + 1'b1 || cur_code == $past(cur_code) - 1'b1);
  endproperty
  a_one_lsb: assert property (p_one_lsb) else $error("target moved other than one step");

endmodule

// ---- rtl/cssq_timer.sv ----
// Purpose: One-shot down counter with a single-cycle done pulse.
// Assumes: load_value of at least 1.
// Notes: clear wins over load.
`timescale 1ns/1ps
module cssq_timer
  import cssq_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic clear,
  input wire logic load,
  input wire logic [TMR_W-1:0] load_value,
  output logic busy,
  output logic done
);

  logic [TMR_W-1:0] count;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      count <= '0;
      done <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (clear) begin
        count <= '0;
      end else if (load) begin
        count <= load_value;
      end else if (count != '0) begin
        count <= count - 1'b1;
        done <= (count == 1);
      end
    end
  end

  assign busy = (count != '0);

  property p_done_from_one;
    @(posedge clk_sys) disable iff (!resetn)
    (done && $past(clk_en)) |-> $past(count) == 1 && count == '0;
  endproperty
  a_done_from_one: assert property (p_done_from_one) else $error("timer done not from one");

endmodule

// ---- shared/cssq_pkg.sv ----
// Purpose: Constants and decoding shared by the core supply startup sequencer.
// Assumes: clk_sys at 40 MHz; voltage levels in units of 0.1 mV.
// Notes: Code 7'h00 is the highest DAC level; codes step down 12.5 mV each.
//
// Notes on behaviour
// - Good flag high inside -300/+200 mV window.
// - Below 300 mV target, check upper limit only.
// - Mask good check after code or sleep changes.
// - Mask lasts about 100 us, internal clock.
// - Startup steps target one code at a time.
// - Soft-start begins only after enable is high.
// - Hold boot level 100 us, then release clock.
// - Good flag rises 9 ms after clock release.
// - Short sense reference while in lockout or shutdown.
// - Reset interval 50 to 60 us after power up.
// - Detect phase count, then issue go signal.
// - Ignore select inputs until clock is released.
// - Reference from 7-bit code minus droop.
// - Move target one LSB per microsecond.
// - Wait 400 ns after select inputs change.
// - Each code change restarts the mask timer.
package cssq_pkg;

  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int unsigned RST_MIN_NS = 50_000;
  localparam int unsigned RST_MAX_NS = 60_000;
  localparam int unsigned RST_CYC = (RST_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned RST_MAX_CYC = RST_MAX_NS / CLK_NS;
  localparam int unsigned BOOT_NS = 100_000;
  localparam int unsigned BOOT_CYC = BOOT_NS / CLK_NS;
  localparam int unsigned MASK_NS = 100_000;
  localparam int unsigned MASK_CYC = MASK_NS / CLK_NS;
  localparam int unsigned STEP_NS = 1_000;
  localparam int unsigned STEP_CYC = STEP_NS / CLK_NS;
  localparam int unsigned DEGL_NS = 400;
  localparam int unsigned DEGL_CYC = (DEGL_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned PG_DELAY_NS = 9_000_000;
  localparam int unsigned PG_DELAY_DEF = PG_DELAY_NS / CLK_NS;
  localparam int unsigned PHASE_DET_CYC = 3;

  localparam int TMR_W = 19;
  localparam int STEP_W = 6;
  localparam int DEGL_W = 5;
  localparam int LVL_W = 16;
  localparam int CODE_W = 7;
  localparam int SYNC_W = 12;

  // ==========================================================
  // Voltage levels, 0.1 mV units
  // ==========================================================
  localparam logic [LVL_W-1:0] FULL_LVL = 16'h3A98;
  localparam logic [LVL_W-1:0] LSB_LVL = 16'h007D;
  localparam logic [LVL_W:0] WIN_LO_LVL = 17'h0_0BB8;
  localparam logic [LVL_W:0] WIN_HI_LVL = 17'h0_07D0;
  localparam logic [LVL_W-1:0] LOW_DAC_LVL = 16'h0BB8;
  localparam logic [CODE_W-1:0] ZERO_CODE = 7'h78;
  localparam logic [CODE_W-1:0] BOOT_CODE_DEF = 7'h20;

  // Phase count encodings
  localparam logic [1:0] PH_ONE = 2'h1;
  localparam logic [1:0] PH_TWO = 2'h2;
  localparam logic [1:0] PH_THREE = 2'h3;

  typedef enum logic [2:0] {
    ST_SHUTDOWN = 3'b000,
    ST_RESET = 3'b001,
    ST_PHASE = 3'b010,
    ST_SOFT = 3'b011,
    ST_BOOT = 3'b100,
    ST_PGDLY = 3'b101,
    ST_RUN = 3'b110
  } cssq_state_t;

  // DAC code to level, clamped at zero
  function automatic logic [LVL_W-1:0] code_to_level(input logic [CODE_W-1:0] code);
    logic [LVL_W+CODE_W-1:0] drop;
    drop = {{LVL_W{1'b0}}, code} * {{CODE_W{1'b0}}, LSB_LVL};
    if (drop >= {{CODE_W{1'b0}}, FULL_LVL}) begin
      return '0;
    end
    return FULL_LVL - drop[LVL_W-1:0];
  endfunction

endpackage

// ---- testbench/cssq_cpu_model.sv ----
// Purpose: Host processor model driving the code and sleep pins.
// Assumes: Pins change just after rising clk_sys edges.
// Notes: Codes only ever move one step at a time.
`timescale 1ns/1ps
module cssq_cpu_model
  import cssq_pkg::*;
(
  input wire logic clk_sys,
  output logic [CODE_W-1:0] code,
  output logic sleep
);
  // ==========================================================
  // Pin state
  // ==========================================================
  initial begin
    code = BOOT_CODE_DEF + 7'h01;
    sleep = 1'b0;
  end

  // ==========================================================
  // Requests
  // ==========================================================
  task automatic step_to(input logic [CODE_W-1:0] goal, input int gap);
    while (code != goal) begin
      @(posedge clk_sys);
      code <= (goal > code) ? code + 7'h01 : code - 7'h01;
      repeat (gap) @(posedge clk_sys);
    end
  endtask

  task automatic toggle_sleep();
    @(posedge clk_sys);
    sleep <= ~sleep;
  endtask
endmodule

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the core supply startup sequencer.
// Assumes: 40 MHz clock; power-good delay shortened to PGD cycles.
// Notes: Timing figures are checked in cycles of clk_sys.
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module testbench
  import cssq_pkg::*;
;
  localparam int unsigned PGD = 50;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic enable = 1'b0;
  logic lockout = 1'b0;
  logic clk_en = 1'b1;
  logic p2 = 1'b0;
  logic p3 = 1'b1;
  logic [LVL_W-1:0] sense = '0;
  logic [LVL_W-1:0] droop = '0;
  logic good, rel_n, short, bias, go;
  logic [1:0] ph;
  logic [CODE_W-1:0] tgt, vsi;
  logic [LVL_W-1:0] ref_lvl;
  logic dsr;
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;

  // ==========================================================
  // Clock, instances, timeout
  // ==========================================================
  always #12.5 clk_sys = ~clk_sys;

  cssq_cpu_model i_cpu (.clk_sys(clk_sys), .code(vsi), .sleep(dsr));

  cssq_sequencer #(.PG_DELAY_CYC(PGD), .BOOT_CODE(BOOT_CODE_DEF)) i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .enable(enable),
    .supply_lockout(lockout), .deep_sleep_request(dsr), .voltage_select_inputs(vsi),
    .phase2_pullup(p2), .phase3_pullup(p3), .sense_level(sense),
    .droop_level(droop), .output_good_flag(good), .clock_release_n(rel_n),
    .output_sense_ref_short(short), .bias_enable(bias), .soft_start_go(go),
    .phase_count(ph), .target_code(tgt), .reference_level(ref_lvl)
  );

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      finish_test();
    end
  end

  // ==========================================================
  // Helpers
  // ==========================================================
  task automatic finish_test();
    if (fails == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  function automatic int lvl(input logic [CODE_W-1:0] c);
    return (c >= 7'h78) ? 0 : 15000 - 125 * int'(c);
  endfunction

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_startup();
    int n;
    logic [CODE_W-1:0] prev;
    bit ok;
    #1;
    `CHK("short_idle", 1'b1, short)
    tick(40);
    #1;
    `CHK("bias_idle", 1'b0, bias)
    `CHK("target_idle", 7'h78, tgt)
    tick(1);
    enable <= 1'b1;
    n = 0;
    while (go !== 1'b1 && n < 3000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `CHK("bias_on", 1'b1, bias)
    `CHK("reset_len", 1'b1, n >= 2000 && n <= 2400)
    `CHK("phases", 2'h2, ph)
    ok = 1;
    prev = tgt;
    n = 0;
    while (tgt !== BOOT_CODE_DEF && n < 5000) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (tgt !== prev && tgt !== prev - 7'h01) ok = 0;
      prev = tgt;
    end
    `CHK("soft_step", 1'b1, ok)
    n = 0;
    while (rel_n !== 1'b0 && n < 5000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `CHK("boot_code", BOOT_CODE_DEF, tgt)
    `CHK("boot_len", 1'b1, n >= 3999 && n <= 4002)
    n = 0;
    while (good !== 1'b1 && n < 200) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    `CHK("good_delay", 1'b1, n >= PGD - 1 && n <= PGD + 2)
  endtask

  task automatic t_slew();
    int n, last;
    logic [CODE_W-1:0] prev;
    bit ok_wait, ok_rate;
    tick(100);
    droop <= 16'h01F4;
    fork
      i_cpu.step_to(7'h25, 20);
    join_none
    ok_wait = 1;
    ok_rate = 1;
    prev = tgt;
    last = 0;
    n = 0;
    while (tgt !== 7'h25 && n < 400) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (tgt !== prev) begin
        if (last == 0) ok_wait = (n >= DEGL_CYC + STEP_CYC + 2 && n <= DEGL_CYC + STEP_CYC + 6);
        else if (n - last < 39 || n - last > 41) ok_rate = 0;
        if (tgt !== prev + 7'h01) ok_rate = 0;
        last = n;
        prev = tgt;
      end
    end
    `CHK("deglitch", 1'b1, ok_wait)
    `CHK("slew_rate", 1'b1, ok_rate)
    tick(3);
    #1;
    `CHK("reference", LVL_W'(lvl(7'h25) - 500), ref_lvl)
    tick(1);
    droop <= '0;
  endtask

  task automatic t_window();
    int off [4] = '{2000, 2001, -3000, -3001};
    logic exp_good [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
    tick(4100);
    for (int i = 0; i < 4; i++) begin
      tick(1);
      sense <= LVL_W'(lvl(7'h25) + off[i]);
      tick(3);
      #1;
      `CHK("window", exp_good[i], good)
    end
  endtask

  task automatic t_mask();
    tick(1);
    sense <= LVL_W'(lvl(7'h25));
    tick(3);
    i_cpu.toggle_sleep();
    tick(4);
    sense <= 16'hFFFF;
    tick(3000);
    #1;
    `CHK("mask_sleep", 1'b1, good)
    i_cpu.step_to(7'h26, 20);
    tick(1500);
    #1;
    `CHK("mask_restart", 1'b1, good)
    tick(2600);
    #1;
    `CHK("mask_end", 1'b0, good)
  endtask

  task automatic t_low_dac();
    i_cpu.step_to(7'h62, 1);
    tick(4200);
    sense <= LVL_W'(lvl(7'h62) + 2000);
    tick(3);
    #1;
    `CHK("low_dac_tgt", 7'h62, tgt)
    `CHK("low_dac_in", 1'b1, good)
    tick(1);
    sense <= LVL_W'(lvl(7'h62) + 2001);
    tick(3);
    #1;
    `CHK("low_dac_hi", 1'b0, good)
  endtask

  task automatic t_shutdown();
    tick(1);
    sense <= LVL_W'(lvl(7'h26));
    tick(1);
    lockout <= 1'b1;
    tick(5);
    #1;
    `CHK("off_good", 1'b0, good)
    `CHK("off_release", 1'b1, rel_n)
    `CHK("off_target", 7'h78, tgt)
    `CHK("off_short", 1'b1, short)
    tick(1);
    lockout <= 1'b0;
    enable <= 1'b0;
    tick(50);
    #1;
    `CHK("en_low_bias", 1'b0, bias)
    tick(1);
    enable <= 1'b1;
    tick(6);
    #1;
    `CHK("en_bias", 1'b1, bias)
    tick(1);
    clk_en <= 1'b0;
    enable <= 1'b0;
    tick(10);
    #1;
    `CHK("freeze_bias", 1'b1, bias)
    tick(1);
    clk_en <= 1'b1;
    tick(5);
    #1;
    `CHK("en_off_short", 1'b1, short)
    tick(1);
    p2 <= 1'b1;
    enable <= 1'b1;
    tick(2100);
    #1;
    `CHK("one_phase", PH_ONE, ph)
  endtask

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    t_startup();
    t_slew();
    t_window();
    t_mask();
    t_low_dac();
    t_shutdown();
    finish_test();
  end
endmodule
